// ---- design/rmcr_pkg.sv ----
// Package of constants for the retimer misc and output swing control registers.
// Functional notes
// - Termination select sits at bits 4:3 of the first register, resets to 00, 10 reserved.
// - In pin configuration mode, termination writes are ignored and the strap pin is shown.
// - Bit 2 of the first register selects bridge speed, 0 for 100 kbps and 1 for 400 kbps.
// - A source-side write to target 0xA8 offset 0x20 copies its bit 1 into the clock-ratio flag.
// - Clock-ratio flag 0 means clock is one tenth of bit rate, 1 means one fortieth.
// - Bit 0 of the first register at 1 disables training and keeps legacy modes only.
// - Setting training off forces the one-fortieth clock-ratio mode.
// - Bits 7:5 of the second register set data swing in eight steps, reset 000.
// - Bits 4:2 of the second register set clock swing with the same encoding.
// - Bits 1:0 of the second register set de-emphasis, retimer mode only, 10 and 11 reserved.
// - De-emphasis mirrors its strap pin and ignores writes in pin configuration mode.
// - Termination, de-emphasis and swing take effect only when the commit bit is written.
// - In one-fortieth mode the clock swing is halved unless the half-swing inhibit is 1.
`default_nettype none

package rmcr_pkg;

    localparam logic [7:0] RMCR_MISC_OFFSET = 8'h0B;
    localparam logic [7:0] RMCR_SWING_OFFSET = 8'h0C;
    localparam int RMCR_TERM_LSB = 3;
    localparam int RMCR_SPEED_BIT = 2;
    localparam int RMCR_RATIO_BIT = 1;
    localparam int RMCR_TRAIN_BIT = 0;
    localparam int RMCR_DSWING_LSB = 5;
    localparam int RMCR_CSWING_LSB = 2;
    localparam int RMCR_DEEMPH_LSB = 0;
    localparam logic [1:0] RMCR_TERM_RESET = 2'h0;
    localparam logic [2:0] RMCR_SWING_RESET = 3'h0;
    localparam logic [1:0] RMCR_DEEMPH_RESET = 2'h0;
    localparam logic [6:0] RMCR_SNOOP_TARGET = 7'h54;
    localparam logic [7:0] RMCR_SNOOP_OFFSET = 8'h20;
    localparam int RMCR_SNOOP_BIT = 1;
    localparam int RMCR_CLK_MHZ = 200;
    localparam int RMCR_HPD_LOW_US = 2000;
    localparam int RMCR_HPD_LOW_CYCLES = RMCR_HPD_LOW_US * RMCR_CLK_MHZ;

endpackage

`default_nettype wire

// ---- design/rmcr_regs.sv ----
// Misc link control and output swing control registers with snooped clock-ratio flag.
`default_nettype none

module rmcr_regs (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic CONFIG_FROM_REGS,
    input wire logic [1:0] TERM_STRAP,
    input wire logic [1:0] DEEMPH_STRAP,
    input wire logic SOURCE_SCL,
    input wire logic SOURCE_SDA,
    input wire logic SINK_HOTPLUG,
    input wire logic COMMIT,
    input wire logic CLOCK_HALF_SWING_INHIBIT,
    input wire logic RETIMER_MODE,
    output logic [1:0] TX_TERMINATION_SELECT,
    output logic BRIDGE_SPEED_SELECT,
    output logic CLOCK_RATIO_FLAG,
    output logic TRAINING_OFF,
    output logic [2:0] DATA_LANE_SWING_ADJUST,
    output logic [2:0] CLOCK_LANE_SWING_ADJUST,
    output logic CLOCK_SWING_HALF,
    output logic [1:0] POSTCURSOR_DEEMPH_WEIGHT
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before logic reads the config, strap, channel, hot-plug and commit levels.
    logic [8:0] sync1, sync2;
    logic pin_mode, hpd, scl_s, sda_s;
    logic [1:0] term_pin, deemph_pin;

    always_ff @(posedge SYS_CLK) begin
        sync1 <= {CONFIG_FROM_REGS, TERM_STRAP, DEEMPH_STRAP, SOURCE_SCL, SOURCE_SDA,
            SINK_HOTPLUG, COMMIT};
        sync2 <= sync1;
    end

    // Pin configuration mode is a low select.
    assign pin_mode = ~sync2[8];
    assign term_pin = sync2[7:6];
    assign deemph_pin = sync2[5:4];
    assign scl_s = sync2[3];
    assign sda_s = sync2[2];
    assign hpd = sync2[1];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Source-side channel watcher.
    logic snoop_hit, snoop_value;

    rmcr_snoop u_snoop (
        .clk(SYS_CLK),
        .srst(SRST),
        .scl(scl_s),
        .sda(sda_s),
        .hit(snoop_hit),
        .hit_value(snoop_value)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [1:0] term, next_term;
    logic speed, next_speed;
    logic ratio, next_ratio;
    logic train_off, next_train_off;
    logic [2:0] dswing, next_dswing;
    logic [2:0] cswing, next_cswing;
    logic [1:0] deemph, next_deemph;
    logic [31:0] low_cnt, next_low_cnt;
    logic commit_d, next_commit_d;
    logic [1:0] next_out_term, next_out_deemph;
    logic [2:0] next_out_dswing, next_out_cswing;
    logic next_half;
    logic [7:0] next_rdata;
    logic wr_misc, wr_swing, hpd_expired, commit_pulse;

    // Address decode, used for both writes and reads.
    function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
        hits = (a == off);
    endfunction

    assign wr_misc = REG_WR & hits(REG_ADDR, rmcr_pkg::RMCR_MISC_OFFSET);
    assign wr_swing = REG_WR & hits(REG_ADDR, rmcr_pkg::RMCR_SWING_OFFSET);
    assign hpd_expired = (low_cnt > rmcr_pkg::RMCR_HPD_LOW_CYCLES);
    assign commit_pulse = sync2[0] & ~commit_d;

    // Next values of the stored fields.
    always_comb begin
        next_term = term;
        next_speed = speed;
        next_ratio = ratio;
        next_train_off = train_off;
        next_dswing = dswing;
        next_cswing = cswing;
        next_deemph = deemph;
        next_commit_d = sync2[0];
        if (pin_mode) begin
            next_term = term_pin;
            next_deemph = deemph_pin;
        end
        if (wr_misc) begin
            if (!pin_mode) begin
                next_term = REG_WDATA[rmcr_pkg::RMCR_TERM_LSB +: 2];
            end
            next_speed = REG_WDATA[rmcr_pkg::RMCR_SPEED_BIT];
            next_ratio = REG_WDATA[rmcr_pkg::RMCR_RATIO_BIT];
            next_train_off = REG_WDATA[rmcr_pkg::RMCR_TRAIN_BIT];
        end
        if (wr_swing) begin
            next_dswing = REG_WDATA[rmcr_pkg::RMCR_DSWING_LSB +: 3];
            next_cswing = REG_WDATA[rmcr_pkg::RMCR_CSWING_LSB +: 3];
            if (!pin_mode) begin
                next_deemph = REG_WDATA[rmcr_pkg::RMCR_DEEMPH_LSB +: 2];
            end
        end
        // Snooped writes win over host writes; expiry of hot-plug clears.
        if (snoop_hit) begin
            next_ratio = snoop_value;
        end
        if (hpd_expired) begin
            next_ratio = 1'b0;
        end
        if (next_train_off) begin
            next_ratio = 1'b1;
        end
    end

    // Hot-plug low timer, saturating just past the limit.
    always_comb begin
        next_low_cnt = 32'h0;
        if (!hpd) begin
            next_low_cnt = hpd_expired ? low_cnt : low_cnt + 32'h1;
        end
    end

    // Applied analog values change only on commit; halving follows the ratio flag.
    always_comb begin
        next_out_term = TX_TERMINATION_SELECT;
        next_out_deemph = POSTCURSOR_DEEMPH_WEIGHT;
        next_out_dswing = DATA_LANE_SWING_ADJUST;
        next_out_cswing = CLOCK_LANE_SWING_ADJUST;
        if (commit_pulse) begin
            next_out_term = term;
            next_out_deemph = RETIMER_MODE ? deemph : rmcr_pkg::RMCR_DEEMPH_RESET;
            next_out_dswing = dswing;
            next_out_cswing = cswing;
        end
        next_half = ratio & ~CLOCK_HALF_SWING_INHIBIT;
    end

    // Read data; reserved bits read zero.
    always_comb begin
        next_rdata = 8'h00;
        if (hits(REG_ADDR, rmcr_pkg::RMCR_MISC_OFFSET)) begin
            next_rdata = {3'h0, term, speed, ratio, train_off};
        end else if (hits(REG_ADDR, rmcr_pkg::RMCR_SWING_OFFSET)) begin
            next_rdata = {dswing, cswing, deemph};
        end
    end

    // Registers of every group.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            term <= rmcr_pkg::RMCR_TERM_RESET;
            speed <= 1'b0;
            ratio <= 1'b0;
            train_off <= 1'b0;
            dswing <= rmcr_pkg::RMCR_SWING_RESET;
            cswing <= rmcr_pkg::RMCR_SWING_RESET;
            deemph <= rmcr_pkg::RMCR_DEEMPH_RESET;
            low_cnt <= 32'h0;
            commit_d <= 1'b0;
            TX_TERMINATION_SELECT <= rmcr_pkg::RMCR_TERM_RESET;
            POSTCURSOR_DEEMPH_WEIGHT <= rmcr_pkg::RMCR_DEEMPH_RESET;
            DATA_LANE_SWING_ADJUST <= rmcr_pkg::RMCR_SWING_RESET;
            CLOCK_LANE_SWING_ADJUST <= rmcr_pkg::RMCR_SWING_RESET;
            CLOCK_SWING_HALF <= 1'b0;
            BRIDGE_SPEED_SELECT <= 1'b0;
            CLOCK_RATIO_FLAG <= 1'b0;
            TRAINING_OFF <= 1'b0;
            REG_RDATA <= 8'h00;
        end else begin
            term <= next_term;
            speed <= next_speed;
            ratio <= next_ratio;
            train_off <= next_train_off;
            dswing <= next_dswing;
            cswing <= next_cswing;
            deemph <= next_deemph;
            low_cnt <= next_low_cnt;
            commit_d <= next_commit_d;
            TX_TERMINATION_SELECT <= next_out_term;
            POSTCURSOR_DEEMPH_WEIGHT <= next_out_deemph;
            DATA_LANE_SWING_ADJUST <= next_out_dswing;
            CLOCK_LANE_SWING_ADJUST <= next_out_cswing;
            CLOCK_SWING_HALF <= next_half;
            BRIDGE_SPEED_SELECT <= speed;
            CLOCK_RATIO_FLAG <= ratio;
            TRAINING_OFF <= train_off;
            REG_RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks of the documented behaviour, one group for each path.

    // A host write that turns training off.
    sequence rmcr_train_write_s;
        wr_misc && REG_WDATA[rmcr_pkg::RMCR_TRAIN_BIT];
    endsequence

    // The synchronised commit level rises; the strobe must come in the second cycle.
    sequence rmcr_commit_rise_s;
        !sync2[0] ##1 sync2[0];
    endsequence

    // Hot-plug is low and the timer has not yet run out.
    sequence rmcr_hpd_low_s;
        !hpd && !hpd_expired;
    endsequence

    // Pin configuration: straps are copied and host writes lose.
    AST_TERM_PIN: assert property (@(posedge SYS_CLK) disable iff (SRST)
        pin_mode |=> term == $past(term_pin))
        else $error("termination does not follow strap in pin mode");
    AST_DEEMPH_PIN: assert property (@(posedge SYS_CLK) disable iff (SRST)
        pin_mode |=> deemph == $past(deemph_pin))
        else $error("de-emphasis does not follow strap in pin mode");

    // Host writes land in the stored fields one cycle later, and on the flag outputs two cycles later.
    AST_TERM_WR: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_misc && !pin_mode |=> term == $past(REG_WDATA[rmcr_pkg::RMCR_TERM_LSB +: 2]))
        else $error("termination write lost");
    AST_DSWING_WR: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_swing |=> dswing == $past(REG_WDATA[rmcr_pkg::RMCR_DSWING_LSB +: 3]))
        else $error("data swing write lost");
    AST_CSWING_WR: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_swing |=> cswing == $past(REG_WDATA[rmcr_pkg::RMCR_CSWING_LSB +: 3]))
        else $error("clock swing write lost");
    AST_DEEMPH_WR: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_swing && !pin_mode |=> deemph == $past(REG_WDATA[rmcr_pkg::RMCR_DEEMPH_LSB +: 2]))
        else $error("de-emphasis write lost");
    AST_SPEED: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_misc |=> ##1 BRIDGE_SPEED_SELECT == $past(REG_WDATA[rmcr_pkg::RMCR_SPEED_BIT], 2))
        else $error("bridge speed output wrong");
    AST_TRAIN_OUT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        wr_misc |=> ##1 TRAINING_OFF == $past(REG_WDATA[rmcr_pkg::RMCR_TRAIN_BIT], 2))
        else $error("training output wrong");
    AST_RSVD: assert property (@(posedge SYS_CLK) disable iff (SRST)
        hits(REG_ADDR, rmcr_pkg::RMCR_MISC_OFFSET) |=> REG_RDATA[7:5] == 3'h0)
        else $error("reserved bits not zero");

    // Clock-ratio flag: training off beats hot-plug expiry, which beats the snooped write.
    AST_TRAIN_FORCE: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_train_write_s |=> ratio ##1 CLOCK_RATIO_FLAG)
        else $error("training off did not force ratio");
    AST_SNOOP: assert property (@(posedge SYS_CLK) disable iff (SRST)
        snoop_hit && !hpd_expired && !next_train_off |=> ratio == $past(snoop_value))
        else $error("snooped value not copied");
    AST_HPD_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SRST)
        hpd_expired && !train_off && !wr_misc |=> !ratio)
        else $error("ratio not cleared after hot-plug low");
    AST_HPD_COUNT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_hpd_low_s |=> low_cnt == $past(low_cnt) + 32'h1)
        else $error("hot-plug low timer did not advance");
    AST_HPD_RESTART: assert property (@(posedge SYS_CLK) disable iff (SRST)
        hpd |=> low_cnt == 32'h0)
        else $error("hot-plug low timer did not restart");
    AST_RATIO_OUT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        1'b1 |=> CLOCK_RATIO_FLAG == $past(ratio))
        else $error("clock-ratio output does not follow flag");

    // Applied analog values move only on the commit strobe, and then take the stored ones, de-emphasis only in retimer mode.
    AST_COMMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !commit_pulse |=> $stable(DATA_LANE_SWING_ADJUST) && $stable(TX_TERMINATION_SELECT)
            && $stable(CLOCK_LANE_SWING_ADJUST) && $stable(POSTCURSOR_DEEMPH_WEIGHT))
        else $error("analog value changed without commit");
    AST_TERM_COMMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_commit_rise_s |=> TX_TERMINATION_SELECT == $past(term))
        else $error("termination not applied on commit");
    AST_DSWING_COMMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_commit_rise_s |=> DATA_LANE_SWING_ADJUST == $past(dswing))
        else $error("data swing not applied on commit");
    AST_CSWING_COMMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_commit_rise_s |=> CLOCK_LANE_SWING_ADJUST == $past(cswing))
        else $error("clock swing not applied on commit");
    AST_DEEMPH_COMMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_commit_rise_s ##0 RETIMER_MODE |=> POSTCURSOR_DEEMPH_WEIGHT == $past(deemph))
        else $error("de-emphasis not applied on commit");
    AST_DEEMPH_LEGACY: assert property (@(posedge SYS_CLK) disable iff (SRST)
        rmcr_commit_rise_s ##0 !RETIMER_MODE |=>
            POSTCURSOR_DEEMPH_WEIGHT == rmcr_pkg::RMCR_DEEMPH_RESET)
        else $error("de-emphasis applied outside retimer mode");

    // Clock swing halving follows the flag unless the inhibit keeps full swing.
    AST_HALF: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ratio && !CLOCK_HALF_SWING_INHIBIT |=> CLOCK_SWING_HALF)
        else $error("clock swing not halved");
    AST_FULL: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !ratio || CLOCK_HALF_SWING_INHIBIT |=> !CLOCK_SWING_HALF)
        else $error("clock swing halved without cause");

endmodule

`default_nettype wire

// ---- design/rmcr_snoop.sv ----
// Passive watcher of the source-side channel that reports writes to the ratio offset.
`default_nettype none

module rmcr_snoop (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    output logic hit,
    output logic hit_value
);

    typedef enum {RMCR_IDLE, RMCR_ADDR, RMCR_OFFS, RMCR_DATA, RMCR_SKIP} rmcr_snoop_t;

    rmcr_snoop_t state, next_state;
    logic scl_d, sda_d;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic match, next_match;
    logic next_hit, next_hit_value;
    logic rise, start, stop;

    // Edge and bus condition detection on already synchronised lines.
    assign rise = scl & ~scl_d;
    assign start = scl & scl_d & sda_d & ~sda;
    assign stop = scl & scl_d & ~sda_d & sda;

    // Bit counting and byte decoding; the ninth clock of each byte is the acknowledge.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_match = match;
        next_hit = 1'b0;
        next_hit_value = hit_value;
        if (start) begin
            next_state = RMCR_ADDR;
            next_cnt = 4'h0;
        end else if (stop) begin
            next_state = RMCR_IDLE;
        end else if (rise && state != RMCR_IDLE && state != RMCR_SKIP) begin
            if (cnt == 4'h8) begin
                next_cnt = 4'h0;
                case (state)
                    RMCR_ADDR: begin
                        next_state = (sh == {rmcr_pkg::RMCR_SNOOP_TARGET, 1'b0}) ?
                            RMCR_OFFS : RMCR_SKIP;
                    end
                    RMCR_OFFS: begin
                        next_match = (sh == rmcr_pkg::RMCR_SNOOP_OFFSET);
                        next_state = RMCR_DATA;
                    end
                    RMCR_DATA: begin
                        next_match = 1'b0;
                        if (match) begin
                            next_hit = 1'b1;
                            next_hit_value = sh[rmcr_pkg::RMCR_SNOOP_BIT];
                        end
                    end
                    default: begin
                        next_state = RMCR_IDLE;
                    end
                endcase
            end else begin
                next_sh = {sh[6:0], sda};
                next_cnt = cnt + 4'h1;
            end
        end
    end

    // State registers of the watcher.
    always_ff @(posedge clk) begin
        scl_d <= scl;
        sda_d <= sda;
        if (srst) begin
            state <= RMCR_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            match <= 1'b0;
            hit <= 1'b0;
            hit_value <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            match <= next_match;
            hit <= next_hit;
            hit_value <= next_hit_value;
        end
    end

endmodule

`default_nettype wire

// ---- tb/rmcr_source_master.sv ----
// Behavioural source-side channel master that writes bytes over the two observed lines.
`default_nettype none

module rmcr_source_master (
    input wire logic clk,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quarter bit time in system clock cycles, slow enough for the two-flop synchronisers.
    localparam int QUARTER = 10;

    // Both lines start high, the idle level of the bus, as driven here at time zero.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waits one quarter bit, then moves just after the clock edge.
    task automatic quarter();
        repeat (QUARTER) @(posedge clk);
        #1;
    endtask

    // Sends one bit; data changes only while the clock line is low.
    task automatic put_bit(input logic b);
        sda = b;
        quarter();
        scl = 1'b1;
        quarter();
        quarter();
        scl = 1'b0;
        quarter();
    endtask

    // Sends a byte most significant bit first, then the sink's acknowledge low.
    task automatic put_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        put_bit(1'b0);
    endtask

    // Start condition, target, offset, data byte, then stop condition.
    task automatic write(input logic [7:0] tgt, input logic [7:0] off, input logic [7:0] dat);
        sda = 1'b0;
        quarter();
        scl = 1'b0;
        quarter();
        put_byte(tgt);
        put_byte(off);
        put_byte(dat);
        sda = 1'b0;
        quarter();
        scl = 1'b1;
        quarter();
        sda = 1'b1;
        quarter();
    endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the misc link and output swing control registers.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic cfg_regs = 1'b1;
    logic [1:0] term_strap = 2'h0;
    logic [1:0] deemph_strap = 2'h0;
    logic scl;
    logic sda;
    logic hotplug = 1'b1;
    logic commit = 1'b0;
    logic inhibit = 1'b0;
    logic retimer = 1'b1;
    logic [1:0] term;
    logic speed;
    logic ratio;
    logic train_off;
    logic [2:0] dsw;
    logic [2:0] csw;
    logic half;
    logic [1:0] deemph;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'hB4C56AF0;
    logic [7:0] m;
    logic [7:0] s;
    logic [9:0] applied = 10'h000;

    rmcr_regs u_rmcr_regs (.SYS_CLK(clk), .SRST(srst), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .CONFIG_FROM_REGS(cfg_regs),
        .TERM_STRAP(term_strap), .DEEMPH_STRAP(deemph_strap), .SOURCE_SCL(scl),
        .SOURCE_SDA(sda), .SINK_HOTPLUG(hotplug), .COMMIT(commit),
        .CLOCK_HALF_SWING_INHIBIT(inhibit), .RETIMER_MODE(retimer),
        .TX_TERMINATION_SELECT(term), .BRIDGE_SPEED_SELECT(speed), .CLOCK_RATIO_FLAG(ratio),
        .TRAINING_OFF(train_off), .DATA_LANE_SWING_ADJUST(dsw),
        .CLOCK_LANE_SWING_ADJUST(csw), .CLOCK_SWING_HALF(half),
        .POSTCURSOR_DEEMPH_WEIGHT(deemph));

    rmcr_source_master u_rmcr_source_master (.clk(clk), .scl(scl), .sda(sda));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 5 ns period and a cycle ceiling that cuts a hang short.
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Expected misc readback: reserved zero, strap in pin mode, training off forces ratio.
    function automatic logic [15:0] misc_exp(logic [7:0] w, logic pin, logic [1:0] strap);
        return {8'h00, 3'h0, pin ? strap : w[4:3], w[2], w[1] | w[0], w[0]};
    endfunction

    // Expected swing readback: de-emphasis follows its strap in pin mode.
    function automatic logic [15:0] swing_exp(logic [7:0] w, logic pin, logic [1:0] strap);
        return {8'h00, w[7:2], pin ? strap : w[1:0]};
    endfunction

    // Compares one value and counts it.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Moves a number of edges on, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One write strobe of one cycle.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask

    // Holds the address until the registered read data has settled.
    task automatic read_check(input string name, input logic [7:0] a, input logic [15:0] exp);
        addr = a;
        tick(3);
        check(name, {8'h00, rdata}, exp);
    endtask

    // Raises the commit bit long enough to pass its synchroniser.
    task automatic do_commit();
        commit = 1'b1;
        tick(4);
        commit = 1'b0;
        tick(4);
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence of scenarios.
    initial begin
        tick(4);
        srst = 1'b0;
        tick(4);
        read_check("misc reset", 8'h0B, 16'h0000);
        read_check("swing reset", 8'h0C, 16'h0000);
        check("reset out", {6'h00, term, dsw, csw, deemph}, 16'h0000);
        check("flags", {12'h000, speed, ratio, train_off, half}, 16'h0000);
        // Register mode: random values with an all-ones corner, then commit.
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 8'hFF : 8'($random(seed));
            s = (i == 0) ? 8'hFF : 8'($random(seed));
            // The host is taken to set its sleep inhibit, held outside this block, first.
            write_reg(8'h0B, m);
            write_reg(8'h0C, s);
            read_check("misc", 8'h0B, misc_exp(m, 1'b0, 2'h0));
            read_check("swing", 8'h0C, swing_exp(s, 1'b0, 2'h0));
            check("speed", {15'h0000, speed}, {15'h0000, m[2]});
            check("training", {15'h0000, train_off}, {15'h0000, m[0]});
            check("forced ratio", {15'h0000, ratio}, {15'h0000, m[1] | m[0]});
            check("held", {6'h00, term, dsw, csw, deemph}, {6'h00, applied});
            do_commit();
            applied = {m[4:3], s[7:2], s[1:0]};
            check("after commit", {6'h00, term, dsw, csw, deemph}, {6'h00, applied});
        end
        write_reg(8'h0B, 8'h00);
        // Snooped writes set and clear the flag; other targets and offsets leave it.
        for (int k = 0; k < 2; k++) begin
            inhibit = k[0];
            u_rmcr_source_master.write(8'hA8, 8'h20, 8'h02);
            tick(8);
            check("snoop set", {15'h0000, ratio}, 16'h0001);
            check("half swing", {15'h0000, half}, {15'h0000, ~inhibit});
            u_rmcr_source_master.write((k == 0) ? 8'hA6 : 8'hA8, (k == 0) ? 8'h20 : 8'h21, 8'h00);
            tick(8);
            check("snoop other", {15'h0000, ratio}, 16'h0001);
            u_rmcr_source_master.write(8'hA8, 8'h20, 8'hFD);
            tick(8);
            check("snoop clear", {15'h0000, ratio}, 16'h0000);
            check("full swing", {15'h0000, half}, 16'h0000);
        end
        // A short hot-plug drop keeps the flag.
        u_rmcr_source_master.write(8'hA8, 8'h20, 8'h02);
        hotplug = 1'b0;
        tick(1000);
        hotplug = 1'b1;
        tick(4);
        check("short drop", {15'h0000, ratio}, 16'h0001);
        write_reg(8'h0B, 8'h00);
        // Pin mode: termination and de-emphasis show the straps and ignore writes.
        cfg_regs = 1'b0;
        for (int j = 0; j < 4; j++) begin
            term_strap = 2'($random(seed));
            deemph_strap = 2'($random(seed));
            retimer = j[0];
            tick(4);
            m = 8'($random(seed));
            s = 8'($random(seed));
            write_reg(8'h0B, m);
            write_reg(8'h0C, s);
            read_check("pin misc", 8'h0B, misc_exp(m, 1'b1, term_strap));
            read_check("pin swing", 8'h0C, swing_exp(s, 1'b1, deemph_strap));
            // Commit applies the straps; de-emphasis only reaches the lanes in retimer mode.
            do_commit();
            applied = {term_strap, s[7:2], retimer ? deemph_strap : 2'h0};
            check("pinned", {6'h00, term, dsw, csw, deemph}, {6'h00, applied});
        end
        read_check("unmapped", 8'h0D, 16'h0000);
        summarize();
    end
endmodule

`default_nettype wire
